// *** rtl/acf_ctrl.v ***
// Function
// [RL1] Three-bit field in config one selects calibration.
// [RL2] Each calibration step lasts seven conversion periods.
// [RL3] Offset calibration stores offset-cancelling correction.
// [RL4] Gain calibration stores gain-cancelling correction.
// [RL5] Software writes offset trim after calibration.
// [RL6] Calibration end sets converter interrupt flag.
// [RL7] Software recalibrates after power-up or changes.
// [RL8] Filter selectable: fast, sinc2, sinc3, auto.
// [RL9] Auto: discard, fast, sinc2, then sinc3.
// [RL10] Settling: sinc3 three, sinc2 two, fast one.
// [RL11] Reference select in config zero, defaults internal 2.5V.
// [RL12] Internal reference level 1.25V or 2.5V.
// [RL13] Software disables unused internal reference.
// [RL14] No valid result flagged during calibration.
`timescale 1ns/1ps
`default_nettype none
`include "acf_regs.vh"
module acf_ctrl (
	input wire clk_sys,
	input wire reset,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	output reg [7:0] sfr_rdata,
	input wire conv_done,
	input wire signed [23:0] conv_raw,
	input wire chan_change,
	input wire flag_clear,
	output reg [1:0] filter_sel,
	output reg result_valid,
	output reg [23:0] result_data,
	output reg adc_irq,
	output reg signed [23:0] offset_corr,
	output reg signed [23:0] gain_corr,
	output wire cal_busy,
	output wire vref_enable,
	output wire vref_high,
	output wire vref_external
);
	// Calibration sequencer states.
	localparam ST_IDLE = 2'b00;
	localparam ST_OFS = 2'b01;
	localparam ST_GAIN = 2'b10;
	// Gain correction target: positive full scale.
	localparam signed [23:0] FULL_SCALE = 24'sh7fffff;

	// Control register storage.
	reg [7:0] cfg0_reg;
	reg [7:0] cfg1_reg;
	// Sequencer state and period counter.
	reg [1:0] state_reg;
	reg [2:0] period_reg;
	// Conversions since the last channel or gain change, saturating at four.
	reg [2:0] settle_reg;
	// Flag that a two-step calibration still owes its gain step.
	reg gain_pending_reg;
	// Calibration completion pulse.
	reg cal_end;

	// Decodes the filter mode in force for the current conversion count.
	function [1:0] pick_filter;
		input [1:0] mode;
		input [2:0] cnt;
		begin
			if (mode != `ACF_FLT_AUTO) begin
				pick_filter = mode;
			end else if (cnt <= 3'd1) begin
				pick_filter = `ACF_FLT_FAST; // RL9
			end else if (cnt == 3'd2) begin
				pick_filter = `ACF_FLT_SINC2; // RL9
			end else begin
				pick_filter = `ACF_FLT_SINC3; // RL9
			end
		end
	endfunction

	wire [1:0] flt_mode = cfg1_reg[`ACF_CFG1_FLT_LSB +: 2];
	wire [2:0] need_cnt;
	wire period_last = (period_reg == `ACF_CAL_PERIODS - 3'h1);
	wire write_cal = sfr_wr && (sfr_addr == `ACF_ADDR_CFG1);

	// Reference controls straight from config zero.
	assign vref_enable = cfg0_reg[`ACF_CFG0_VREF_EN]; // RL11
	assign vref_high = cfg0_reg[`ACF_CFG0_VREF_HI]; // RL12
	assign vref_external = cfg0_reg[`ACF_CFG0_VREF_EXT]; // RL11
	assign cal_busy = (state_reg != ST_IDLE);
	// Settled conversion count needed by a fixed filter.
	assign need_cnt = (flt_mode == `ACF_FLT_SINC3) ? 3'd3 :
		(flt_mode == `ACF_FLT_SINC2) ? 3'd2 : 3'd1; // RL10

	// Register writes; a calibration select field self-clears on completion.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfg0_reg <= `ACF_CFG0_RESET; // RL11
			cfg1_reg <= `ACF_CFG1_RESET;
		end else begin
			if (sfr_wr && sfr_addr == `ACF_ADDR_CFG0) begin
				cfg0_reg <= sfr_wdata;
			end
			if (write_cal) begin
				cfg1_reg <= sfr_wdata;
			end else if (cal_end) begin
				cfg1_reg[`ACF_CFG1_CAL_LSB +: 3] <= `ACF_CAL_NONE;
			end
		end
	end

	// Register reads return stored contents; other addresses read zero.
	always @* begin
		case (sfr_addr)
			`ACF_ADDR_CFG0: begin
				sfr_rdata = cfg0_reg;
			end
			`ACF_ADDR_CFG1: begin
				sfr_rdata = cfg1_reg;
			end
			default: begin
				sfr_rdata = 8'h00;
			end
		endcase
	end

	// Calibration sequencer counting conversion periods.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			period_reg <= 3'h0;
			gain_pending_reg <= 1'b0;
			cal_end <= 1'b0;
			offset_corr <= 24'sh000000;
			gain_corr <= 24'sh000000;
		end else begin
			cal_end <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					period_reg <= 3'h0;
					// A write to config one launches the selected calibration.
					if (write_cal) begin
						case (sfr_wdata[`ACF_CFG1_CAL_LSB +: 3]) // RL1
							`ACF_CAL_OFFSET: begin
								state_reg <= ST_OFS;
								gain_pending_reg <= 1'b0;
							end
							`ACF_CAL_GAIN: begin
								state_reg <= ST_GAIN;
								gain_pending_reg <= 1'b0;
							end
							`ACF_CAL_BOTH: begin
								state_reg <= ST_OFS;
								gain_pending_reg <= 1'b1;
							end
							default: begin
								state_reg <= ST_IDLE;
							end
						endcase
					end
				end
				ST_OFS: begin
					if (conv_done) begin
						period_reg <= period_reg + 3'h1; // RL2
						if (period_last) begin
							// Zero input measured: store its negation.
							offset_corr <= -conv_raw; // RL3
							period_reg <= 3'h0;
							if (gain_pending_reg) begin
								state_reg <= ST_GAIN;
								gain_pending_reg <= 1'b0;
							end else begin
								state_reg <= ST_IDLE;
								cal_end <= 1'b1; // RL6
							end
						end
					end
				end
				ST_GAIN: begin
					if (conv_done) begin
						period_reg <= period_reg + 3'h1; // RL2
						if (period_last) begin
							// Full-scale input measured: store the error to cancel.
							gain_corr <= FULL_SCALE - (conv_raw + offset_corr); // RL4
							period_reg <= 3'h0;
							state_reg <= ST_IDLE;
							cal_end <= 1'b1; // RL6
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Conversion counter restarted by a channel or gain change.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			settle_reg <= 3'h0;
		end else if (chan_change) begin
			settle_reg <= 3'h0;
		end else if (conv_done && settle_reg != 3'h4) begin
			settle_reg <= settle_reg + 3'h1;
		end
	end

	// Filter choice follows the mode and the conversion count.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			filter_sel <= `ACF_FLT_FAST;
		end else begin
			filter_sel <= pick_filter(flt_mode, settle_reg); // RL8
		end
	end

	// Result qualification and the interrupt flag; setting wins over clearing.
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			result_valid <= 1'b0;
			result_data <= 24'h000000;
			adc_irq <= 1'b0;
		end else begin
			result_valid <= 1'b0;
			if (cal_end) begin
				adc_irq <= 1'b1; // RL6
				result_valid <= 1'b1; // RL6
			end else if (conv_done && !cal_busy && !chan_change) begin
				result_data <= conv_raw + offset_corr;
				// Auto drops the first; fixed filters wait for settling.
				if (flt_mode == `ACF_FLT_AUTO ? settle_reg != 3'h0 : // RL9
					settle_reg + 3'h1 >= need_cnt) begin // RL10
					result_valid <= 1'b1; // RL14
					adc_irq <= 1'b1;
				end else if (flag_clear) begin
					adc_irq <= 1'b0;
				end
			end else if (flag_clear) begin
				adc_irq <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/acf_regs.vh ***
`ifndef ACF_REGS_VH
`define ACF_REGS_VH
// Special register addresses of the two converter control registers.
`define ACF_ADDR_CFG0 8'hdc
`define ACF_ADDR_CFG1 8'hdd
// Config zero fields: reference enable, internal level select, external source select.
`define ACF_CFG0_VREF_EN 0
`define ACF_CFG0_VREF_HI 1
`define ACF_CFG0_VREF_EXT 2
// Config zero reset: internal reference on at the 2.5V level.
`define ACF_CFG0_RESET 8'h03
// Config one fields: calibration select [2:0], filter mode [5:4].
`define ACF_CFG1_CAL_LSB 0
`define ACF_CFG1_FLT_LSB 4
`define ACF_CFG1_RESET 8'h00
// Calibration select codes.
`define ACF_CAL_NONE 3'h0
`define ACF_CAL_OFFSET 3'h1
`define ACF_CAL_GAIN 3'h2
`define ACF_CAL_BOTH 3'h3
// Filter mode codes.
`define ACF_FLT_AUTO 2'h0
`define ACF_FLT_FAST 2'h1
`define ACF_FLT_SINC2 2'h2
`define ACF_FLT_SINC3 2'h3
// Conversion periods per single calibration step.
`define ACF_CAL_PERIODS 3'h7
`endif

// *** verification/acf_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port checker for calibration, flag and reference timing.
module acf_chk (
	input wire logic clk_sys, reset, sfr_wr, conv_done, flag_clear,
	input wire logic result_valid, adc_irq, cal_busy, vref_enable, vref_high,
	input wire logic [7:0] sfr_addr, sfr_wdata,
	input wire logic [1:0] filter_sel
);
	logic [3:0] n_reg; // Conversion ends seen during one calibration.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Counts conversion ends while busy and clears when idle.
	always @(posedge clk_sys or posedge reset) begin
		if (reset || !cal_busy) n_reg <= 4'h0;
		else if (conv_done) n_reg <= n_reg + 4'h1;
	end
	cal_start_a: assert property (sfr_wr && sfr_addr == 8'hdd && !sfr_wdata[2]
		&& sfr_wdata[1:0] != 2'h0 && !cal_busy |=> cal_busy) else $error("no start");
	cal_length_a: assert property ($fell(cal_busy) |-> n_reg == 4'h7 || n_reg == 4'he)
		else $error("bad length");
	irq_at_end_a: assert property ($fell(cal_busy) |=> adc_irq && result_valid)
		else $error("no end flag");
	irq_held_a: assert property (adc_irq && !flag_clear |=> adc_irq)
		else $error("flag lost");
	busy_quiet_a: assert property (cal_busy && $past(cal_busy) |-> !result_valid)
		else $error("valid while busy");
	valid_source_a: assert property (result_valid |-> $past(conv_done) || $past(conv_done, 2))
		else $error("stray valid");
	vref_write_a: assert property (sfr_wr && sfr_addr == 8'hdc |=>
		vref_enable == $past(sfr_wdata[0]) && vref_high == $past(sfr_wdata[1])) else $error("vref");
	filter_legal_a: assert property (filter_sel != 2'h0)
		else $error("bad filter");
endmodule
bind acf_ctrl acf_chk i_acf_chk (.clk_sys, .reset, .sfr_wr, .conv_done, .flag_clear,
	.result_valid, .adc_irq, .cal_busy, .vref_enable, .vref_high, .sfr_addr, .sfr_wdata,
	.filter_sel);
`default_nettype wire

// *** verification/acf_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Converter front end: a conversion ends every period+1 cycles.
module acf_model (
	input wire logic clk_sys, reset,
	input wire logic [7:0] period,
	input wire logic [23:0] level,
	output logic conv_done,
	output logic signed [23:0] conv_raw
);
	logic [7:0] cnt_reg; // Cycles since the last conversion end.
	// Raw data holds only with the pulse and toggles otherwise.
	always @(negedge clk_sys or posedge reset) begin
		if (reset) begin
			cnt_reg <= 8'h00;
			conv_done <= 1'b0;
			conv_raw <= 24'h000000;
		end else begin
			conv_done <= cnt_reg == period;
			conv_raw <= (cnt_reg == period) ? level : ~conv_raw;
			cnt_reg <= (cnt_reg == period) ? 8'h00 : cnt_reg + 8'h01;
		end
	end
endmodule
`default_nettype wire

// *** verification/tb_acf_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_acf_ctrl;
	logic clk_sys = 0, reset = 1, sfr_wr = 0, chan_change = 0, flag_clear = 0, mode_auto = 1;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, period = 8'h0f;
	logic [23:0] level = 0, exp_off = 0, result_data, offset_corr, gain_corr;
	logic signed [23:0] conv_raw;
	logic [1:0] filter_sel, bh = 0;
	logic conv_done, result_valid, adc_irq, cal_busy, vref_enable, vref_high, vref_external;
	logic [23:0] q[$]; // Expected results, oldest first.
	int fails = 0, cmp_count = 0, ncv = 0, av = 0, i;
	acf_ctrl i_acf_ctrl (.clk_sys, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rdata, .conv_done,
		.conv_raw, .chan_change, .flag_clear, .filter_sel, .result_valid, .result_data, .adc_irq,
		.offset_corr, .gain_corr, .cal_busy, .vref_enable, .vref_high, .vref_external);
	acf_model i_acf_model (.clk_sys, .reset, .period, .level, .conv_done, .conv_raw);
	initial forever #20 clk_sys = ~clk_sys;
	task chk(input string n, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge clk_sys);
		sfr_wr = 0;
	endtask
	// One-cycle pulse on the flag clear strobe, driven on falling edges.
	task pulse_clear;
		@(negedge clk_sys);
		flag_clear = 1;
		@(negedge clk_sys);
		flag_clear = 0;
	endtask
	// One-cycle pulse on the channel change strobe, driven on falling edges.
	task pulse_chan;
		@(negedge clk_sys);
		chan_change = 1;
		@(negedge clk_sys);
		chan_change = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(negedge clk_sys);
		sfr_addr = a;
		#1 chk(n, {16'h0, e}, {16'h0, sfr_rdata});
	endtask
	task wait_conv(input int n);
		repeat (n) @(posedge clk_sys iff conv_done);
		repeat (2) @(negedge clk_sys);
	endtask
	// Runs one calibration in fast filter mode and checks its outcome.
	task cal(input logic [2:0] c, input logic [23:0] eo, input logic [23:0] eg);
		ncv = 0;
		wr(8'hdd, {5'h02, c});
		// Earlier conversions left the flag up; clear it so the end event is seen.
		pulse_clear;
		chk("adc_irq busy", 24'h0, {23'h0, adc_irq});
		while (cal_busy) @(negedge clk_sys);
		// The new correction applies only from the end of the calibration on.
		exp_off = eo;
		@(negedge clk_sys);
		chk("adc_irq", 24'h1, {23'h0, adc_irq});
		chk("periods", c == 3'h3 ? 24'd14 : 24'd7, ncv[23:0]);
		chk("offset_corr", eo, offset_corr);
		chk("gain_corr", eg, gain_corr);
		rd(8'hdd, 8'h10, "cal field");
		pulse_clear;
		chk("adc_irq", 24'h0, {23'h0, adc_irq});
		$display("calibration %0d done", c);
	endtask
	// Notes the expected result of each conversion outside calibration while mode_auto is low.
	always @(posedge clk_sys) begin
		if (conv_done && cal_busy) ncv++;
		if (conv_done && !cal_busy && !mode_auto) q.push_back(conv_raw + exp_off);
	end
	// Compares each result while mode_auto is low, skipping the one that ends a calibration; counts results while it is high.
	always @(negedge clk_sys) begin
		if (result_valid && mode_auto) av++;
		else if (result_valid && !bh[1]) chk("result_data", q.pop_front(), result_data);
		bh = {bh[0], cal_busy};
	end
	task close_out;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		$display("watchdog expired");
		close_out;
	end
	initial begin
		void'($urandom(61238));
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 0;
		rd(8'hdc, 8'h03, "cfg0 reset");
		rd(8'hdd, 8'h00, "cfg1 reset");
		rd(8'h5a, 8'h00, "unmapped");
		// Every reference code, internal reference off among them.
		for (i = 0; i < 8; i++) begin
			wr(8'hdc, i[7:0]);
			chk("vref", i[23:0], {21'h0, vref_external, vref_high, vref_enable});
		end
		$display("reference test done");
		// Switch the scoreboard mode in a quiet gap just after a result.
		wait_conv(1);
		level = $urandom;
		mode_auto = 0;
		// the offset trim sits outside this block and is left alone until calibration ends.
		cal(3'h1, -level, 24'h0);
		wait_conv(4);
		@(posedge clk_sys);
		level = $urandom;
		cal(3'h2, exp_off, 24'h7fffff - (level + exp_off));
		@(posedge clk_sys);
		level = $urandom;
		cal(3'h3, -level, 24'h7fffff);
		wait_conv(3);
		mode_auto = 1;
		for (i = 1; i < 4; i++) begin
			wr(8'hdd, {2'h0, i[1:0], 4'h0});
			wait_conv(3);
			chk("filter_sel", i[23:0], {22'h0, filter_sel});
			// After a change, a fixed filter holds back results until it has settled.
			pulse_chan;
			av = 0;
			wait_conv(3);
			chk("settled results", 24'd4 - i[23:0], av[23:0]);
		end
		// Automatic sequence restarts on a channel change.
		wr(8'hdd, 8'h00);
		wait_conv(1);
		chan_change = 1;
		@(negedge clk_sys);
		chan_change = 0;
		av = 0;
		wait_conv(4);
		chk("auto results", 24'd3, av[23:0]);
		chk("auto filter", 24'h3, {22'h0, filter_sel});
		$display("filter tests done");
		close_out;
	end
endmodule
`default_nettype wire
